// file: logic/bsp_pkg.sv
// Constants and types for the boot select and power mode block
package bsp_pkg;
    localparam int NPER = 8;

    typedef enum logic [2:0] {
        BSP_SRC_ROM = 3'b000,
        BSP_SRC_EBU = 3'b001,
        BSP_SRC_BUS = 3'b010,
        BSP_SRC_HALT = 3'b011,
        BSP_SRC_EMU = 3'b100,
        BSP_SRC_TRIST = 3'b101,
        BSP_SRC_RSVD = 3'b110
    } bsp_src_t;

    typedef enum logic [2:0] {
        BSP_PM_RUN = 3'b000,
        BSP_PM_IDLE = 3'b001,
        BSP_PM_SSHUT = 3'b010,
        BSP_PM_SLEEP = 3'b011,
        BSP_PM_DSHUT = 3'b100,
        BSP_PM_DEEP = 3'b101,
        BSP_PM_WAKE = 3'b110
    } bsp_pm_t;

    typedef struct packed {
        bsp_src_t src;
        logic [31:0] pc;
        logic ebu_en;
        logic ebu_master;
    } bsp_boot_t;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_SLPEN = 8'h08;
    localparam logic [7:0] OFS_WAKEN = 8'h0c;
    localparam logic [7:0] OFS_PEREN = 8'h10;
    localparam logic [7:0] OFS_BOOT = 8'h14;
    // Field positions
    localparam int CTRL_SWRST_BIT = 4;
    localparam int STAT_SRC_LSB = 4;
    localparam int STAT_EBU_BIT = 8;
    localparam int STAT_MST_BIT = 9;
    // Reset values
    localparam logic [NPER-1:0] SLPEN_RST = 8'h00;
    localparam logic [NPER-1:0] WAKEN_RST = 8'hff;
    localparam logic [NPER-1:0] PEREN_RST = 8'hff;
    // Boot decode
    localparam logic [31:0] PC_ROM = 32'hbfff_fffc;
    localparam logic [31:0] PC_EXT = 32'ha000_0000;
    localparam logic [31:0] PC_EMU = 32'hbe00_0000;
    localparam logic [2:0] CFG_ROM_MAX = 3'h2;
    localparam logic [2:0] CFG_EBU = 3'h4;
    localparam logic [2:0] CFG_BUS = 3'h5;
    // Software mode codes
    localparam logic [1:0] MODE_RUN = 2'h0;
    localparam logic [1:0] MODE_IDLE = 2'h1;
    localparam logic [1:0] MODE_SLEEP = 2'h2;
    localparam logic [1:0] MODE_DEEP = 2'h3;
    // Timing
    localparam int CLK_NS = 40;
    localparam int HRST_NS = 1000;
    localparam int LOCK_NS = 2000;
    localparam logic [7:0] HRST_CYC = 8'((HRST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] LOCK_CYC = 8'((LOCK_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SHUT_CYC = 8'h04;
endpackage

// file: logic/bsp_rst_gen.sv
// Reset pulse generator for internal and external hard reset
`timescale 1ns/100ps
module bsp_rst_gen
    import bsp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req,
    output logic sys_rst_q,
    output logic hard_reset_output_q
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    assign cnt_d = req ? HRST_CYC : (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= HRST_CYC;
            sys_rst_q <= 1'b1;
            hard_reset_output_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_d;
            sys_rst_q <= (cnt_d != 8'h00);
            hard_reset_output_q <= (cnt_d != 8'h00);
        end
    end

    hrst_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        req |=> hard_reset_output_q [*8])
        else $error("hard reset pulse too short");
    hrst_end_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(hard_reset_output_q) |-> $past(cnt_q) == 8'h01 && !$past(req))
        else $error("hard reset ended early");
endmodule

// file: logic/bsp_top.sv
// Boot strap decode, power mode state machine and register slave
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module bsp_top
    import bsp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic debug_enable_strap,
    input wire logic break_in_strap,
    input wire logic [3:0] boot_cfg,
    input wire logic [NPER-1:0] periph_irq,
    input wire logic wdt_event,
    input wire logic wdt_reset_req,
    input wire logic nmi_n,
    input wire logic ext_wake,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic cpu_clk_en_q,
    output logic [NPER-1:0] periph_clk_en_q,
    output logic sys_clk_en_q,
    output logic pll_en_q,
    output logic [1:0] pm_mode_q,
    output bsp_boot_t boot_q,
    output logic sys_rst_q,
    output logic hard_reset_output_q
);
    bsp_pm_t state_q;
    bsp_pm_t state_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic taken_q;
    logic nmi_q;
    logic [NPER-1:0] slpen_q;
    logic [NPER-1:0] waken_q;
    logic [NPER-1:0] peren_q;
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // Reset generation; watchdog and software requests share one pulse
    logic sw_rst;
    logic rst_req;
    assign rst_req = wdt_reset_req | sw_rst;
    bsp_rst_gen u_rst
    (
        .core_clk(core_clk),
        .rst(rst),
        .req(rst_req),
        .sys_rst_q(sys_rst_q),
        .hard_reset_output_q(hard_reset_output_q)
    );

    logic take;
    assign take = !taken_q && !sys_rst_q;

    // Boot decode
    logic [2:0] cfg_lo;
    logic ebu_code;
    bsp_src_t src_w;
    bsp_boot_t boot_w;
    assign cfg_lo = boot_cfg[2:0];
    assign ebu_code = (cfg_lo == CFG_EBU) || (cfg_lo == CFG_BUS);
    assign src_w = !break_in_strap ? (debug_enable_strap ? BSP_SRC_TRIST : BSP_SRC_EMU) :
                   !debug_enable_strap ? BSP_SRC_HALT :
                   (cfg_lo <= CFG_ROM_MAX) ? BSP_SRC_ROM :
                   (cfg_lo == CFG_EBU) ? BSP_SRC_EBU :
                   (cfg_lo == CFG_BUS) ? BSP_SRC_BUS : BSP_SRC_RSVD;
    assign boot_w.src = src_w;
    assign boot_w.pc = (src_w == BSP_SRC_ROM) ? PC_ROM :
                       (src_w == BSP_SRC_EBU || src_w == BSP_SRC_BUS) ? PC_EXT :
                       (src_w == BSP_SRC_EMU) ? PC_EMU : 32'h0000_0000;
    assign boot_w.ebu_en = (src_w == BSP_SRC_EBU) || (src_w == BSP_SRC_BUS) ||
                           (src_w == BSP_SRC_HALT && ebu_code);
    assign boot_w.ebu_master = boot_w.ebu_en && boot_cfg[3];

    // Write path decode
    logic wr_fire;
    logic wr_ok;
    logic wr_b0;
    logic pm_req;
    logic [1:0] req_mode;
    assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
    assign wr_ok = (waddr_q == OFS_CTRL) || (waddr_q == OFS_SLPEN) || (waddr_q == OFS_WAKEN) ||
                   (waddr_q == OFS_PEREN) || (waddr_q == OFS_STAT) || (waddr_q == OFS_BOOT);
    assign wr_b0 = wr_fire && wstrb_q[0];
    assign pm_req = wr_b0 && (waddr_q == OFS_CTRL);
    assign req_mode = wdata_q[1:0];
    assign sw_rst = pm_req && wdata_q[CTRL_SWRST_BIT];

    // Wake sources
    logic nmi_fall;
    logic wake_idle;
    logic wake_sleep;
    assign nmi_fall = nmi_q && !nmi_n;
    assign wake_idle = wdt_event || nmi_fall || |(periph_irq & waken_q);
    // Only peripherals still running in sleep can wake it
    assign wake_sleep = wdt_event || nmi_fall || |(periph_irq & slpen_q & waken_q);

    always_comb
    begin
        state_d = state_q;
        cnt_d = (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
        unique case (state_q)
            BSP_PM_RUN:
            begin
                if (take && src_w == BSP_SRC_TRIST)
                begin
                    state_d = BSP_PM_DSHUT;
                    cnt_d = SHUT_CYC;
                end
                else if (pm_req && req_mode == MODE_IDLE)
                    state_d = BSP_PM_IDLE;
                else if (pm_req && req_mode == MODE_SLEEP)
                begin
                    state_d = BSP_PM_SSHUT;
                    cnt_d = SHUT_CYC;
                end
                else if (pm_req && req_mode == MODE_DEEP)
                begin
                    state_d = BSP_PM_DSHUT;
                    cnt_d = SHUT_CYC;
                end
            end
            BSP_PM_IDLE:
                if (wake_idle)
                    state_d = BSP_PM_RUN;
            BSP_PM_SSHUT:
                if (cnt_q == 8'h01)
                    state_d = BSP_PM_SLEEP;
            BSP_PM_SLEEP:
                if (wake_sleep)
                    state_d = BSP_PM_RUN;
            BSP_PM_DSHUT:
                if (cnt_q == 8'h01)
                    state_d = BSP_PM_DEEP;
            BSP_PM_DEEP:
                if (ext_wake)
                begin
                    state_d = BSP_PM_WAKE;
                    cnt_d = LOCK_CYC;
                end
            BSP_PM_WAKE:
                if (cnt_q == 8'h01)
                    state_d = BSP_PM_RUN;
            default:
                state_d = BSP_PM_RUN;
        endcase
    end

    // Clock enables from state
    logic cpu_d;
    logic sys_d;
    logic pll_d;
    logic [1:0] mode_d;
    logic [NPER-1:0] per_d;
    // Only run keeps the processor clock
    assign cpu_d = (state_q == BSP_PM_RUN);
    // Loop and system clock off in deep sleep
    assign sys_d = (state_q != BSP_PM_DEEP);
    assign pll_d = (state_q != BSP_PM_DEEP);
    assign mode_d = (state_q == BSP_PM_RUN) ? MODE_RUN :
                    (state_q == BSP_PM_IDLE) ? MODE_IDLE :
                    (state_q == BSP_PM_SSHUT || state_q == BSP_PM_SLEEP) ? MODE_SLEEP : MODE_DEEP;
    genvar gi;
    generate
        for (gi = 0; gi < NPER; gi++)
        begin : g_per
            assign per_d[gi] = (state_q == BSP_PM_SLEEP) ? (peren_q[gi] & slpen_q[gi]) :
                               (state_q == BSP_PM_DEEP) ? 1'b0 : peren_q[gi];
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= BSP_PM_RUN;
            cnt_q <= 8'h00;
            nmi_q <= 1'b1;
            cpu_clk_en_q <= 1'b1;
            periph_clk_en_q <= PEREN_RST;
            sys_clk_en_q <= 1'b1;
            pll_en_q <= 1'b1;
            pm_mode_q <= MODE_RUN;
        end
        else if (sys_rst_q)
        begin
            state_q <= BSP_PM_RUN;
            cnt_q <= 8'h00;
            nmi_q <= nmi_n;
            cpu_clk_en_q <= 1'b1;
            periph_clk_en_q <= PEREN_RST;
            sys_clk_en_q <= 1'b1;
            pll_en_q <= 1'b1;
            pm_mode_q <= MODE_RUN;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            nmi_q <= nmi_n;
            cpu_clk_en_q <= cpu_d;
            periph_clk_en_q <= per_d;
            sys_clk_en_q <= sys_d;
            pll_en_q <= pll_d;
            pm_mode_q <= mode_d;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            taken_q <= 1'b0;
            boot_q <= '0;
        end
        else if (sys_rst_q)
            taken_q <= 1'b0;
        else if (take)
        begin
            taken_q <= 1'b1;
            boot_q <= boot_w;
        end
    end

    // Software registers; peripheral enables survive watchdog and software reset, reloaded to their reset values only by power-on reset
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            slpen_q <= SLPEN_RST;
            waken_q <= WAKEN_RST;
            peren_q <= PEREN_RST;
        end
        else if (wr_b0)
        begin
            if (waddr_q == OFS_SLPEN)
                slpen_q <= wdata_q[NPER-1:0];
            if (waddr_q == OFS_WAKEN)
                waken_q <= wdata_q[NPER-1:0];
            if (waddr_q == OFS_PEREN)
                peren_q <= wdata_q[NPER-1:0];
        end
    end

    // Bus write channel
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                waddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Bus read channel
    logic [31:0] rd_mux;
    logic rd_ok;
    assign rd_ok = (s_axi_araddr == OFS_CTRL) || (s_axi_araddr == OFS_STAT) ||
                   (s_axi_araddr == OFS_SLPEN) || (s_axi_araddr == OFS_WAKEN) ||
                   (s_axi_araddr == OFS_PEREN) || (s_axi_araddr == OFS_BOOT);
    assign rd_mux = (s_axi_araddr == OFS_STAT) ? {22'h0, boot_q.ebu_master, boot_q.ebu_en,
                        1'b0, boot_q.src, 1'b0, state_q} :
                    (s_axi_araddr == OFS_SLPEN) ? {24'h0, slpen_q} :
                    (s_axi_araddr == OFS_WAKEN) ? {24'h0, waken_q} :
                    (s_axi_araddr == OFS_PEREN) ? {24'h0, peren_q} :
                    (s_axi_araddr == OFS_BOOT) ? boot_q.pc : 32'h0000_0000;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    boot_rom_a: assert property (take && debug_enable_strap && break_in_strap &&
        cfg_lo <= CFG_ROM_MAX |=> boot_q.pc == PC_ROM && boot_q.src == BSP_SRC_ROM)
        else $error("boot rom decode wrong");
    boot_ebu_a: assert property (take && debug_enable_strap && break_in_strap &&
        cfg_lo == CFG_EBU |=> boot_q.pc == PC_EXT && boot_q.ebu_master == $past(boot_cfg[3]))
        else $error("bus unit boot decode wrong");
    boot_bus_a: assert property (take && debug_enable_strap && break_in_strap &&
        cfg_lo == CFG_BUS |=> boot_q.src == BSP_SRC_BUS && boot_q.ebu_en)
        else $error("system bus boot decode wrong");
    halt_ebu_a: assert property (take && !debug_enable_strap && break_in_strap
        |=> boot_q.src == BSP_SRC_HALT && boot_q.ebu_en == $past(ebu_code))
        else $error("halt bus unit enable wrong");
    emul_pc_a: assert property (take && !debug_enable_strap && !break_in_strap
        |=> boot_q.pc == PC_EMU)
        else $error("emulator start wrong");
    trist_deep_a: assert property (take && debug_enable_strap && !break_in_strap
        |=> state_q == BSP_PM_DSHUT)
        else $error("tri-state boot not sleeping");
    boot_hold_a: assert property (taken_q && !sys_rst_q |=> $stable(boot_q))
        else $error("boot outcome changed");
    idle_gate_a: assert property (state_q == BSP_PM_IDLE && !sys_rst_q
        |=> !cpu_clk_en_q && sys_clk_en_q && periph_clk_en_q == $past(peren_q))
        else $error("idle gating wrong");
    idle_entry_a: assert property (state_q == BSP_PM_RUN && pm_req &&
        req_mode == MODE_IDLE && !take && !sys_rst_q |=> state_q == BSP_PM_IDLE)
        else $error("idle not entered");
    idle_wake_a: assert property (state_q == BSP_PM_IDLE && wake_idle
        |=> state_q == BSP_PM_RUN)
        else $error("idle wake missed");
    sleep_gate_a: assert property (state_q == BSP_PM_SLEEP && !sys_rst_q
        |=> periph_clk_en_q == ($past(peren_q) & $past(slpen_q)))
        else $error("sleep gating wrong");
    sleep_wake_a: assert property (state_q == BSP_PM_SLEEP && wake_sleep
        |=> state_q == BSP_PM_RUN)
        else $error("sleep wake missed");
    shut_order_a: assert property ($rose(state_q == BSP_PM_SSHUT) && !sys_rst_q
        |-> ##1 !cpu_clk_en_q ##0 (state_q != BSP_PM_SLEEP) [*3])
        else $error("sleep entered without shutdown");
    deep_off_a: assert property (state_q == BSP_PM_DEEP && !ext_wake && !sys_rst_q
        |=> state_q == BSP_PM_DEEP && !sys_clk_en_q && !pll_en_q)
        else $error("deep sleep clock running");
    run_clk_a: assert property (state_q == BSP_PM_RUN && !sys_rst_q
        |=> cpu_clk_en_q && pll_en_q && periph_clk_en_q == $past(peren_q))
        else $error("run clocks wrong");
    reset_run_a: assert property (sys_rst_q |=> state_q == BSP_PM_RUN && cpu_clk_en_q)
        else $error("reset did not restore run");

    idle_cycle_c: cover property (state_q == BSP_PM_IDLE ##[1:20] state_q == BSP_PM_RUN);
    sleep_cycle_c: cover property (state_q == BSP_PM_SLEEP ##[1:20] state_q == BSP_PM_RUN);
    deep_cycle_c: cover property (state_q == BSP_PM_DEEP ##1 state_q == BSP_PM_WAKE);
    halt_boot_c: cover property (take && src_w == BSP_SRC_HALT && ebu_code);
endmodule

// file: verification/boot_select_power_modes_test.sv
// Testbench for boot decode, power modes and register access
`timescale 1ns/100ps
module boot_select_power_modes_test
    import bsp_pkg::*;
;
    logic core_clk, rst, debug_enable_strap, break_in_strap, wdt_event, wdt_reset_req;
    logic nmi_n, ext_wake, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic cpu_clk_en_q, sys_clk_en_q, pll_en_q, sys_rst_q, hard_reset_output_q;
    logic [5:0] strap_sel;
    logic [3:0] cmd, boot_cfg, s_axi_wstrb;
    logic [NPER-1:0] periph_irq, periph_clk_en_q;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, pm_mode_q;
    bsp_boot_t boot_q, eb;
    logic ec;
    int miscompares, num_checks;
    logic [5:0] tbl [14] = '{6'h30, 6'h3a, 6'h31, 6'h33, 6'h3f, 6'h34, 6'h3c,
        6'h35, 6'h3d, 6'h14, 6'h1d, 6'h18, 6'h05, 6'h25};

    bsp_top i_dut (.*);
    bsp_board_model i_board (.*);

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task give_verdict;
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa, pw;
        @(posedge core_clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
        {pa, pw} = 2'b11;
        while (pa || pw)
        begin
            @(posedge core_clk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(er));
    endtask

    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] er);
        @(posedge core_clk);
        {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'b11, a};
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata & m, e);
        check(32'(s_axi_rresp), 32'(er));
    endtask

    // Wake command held two cycles, then time to settle
    task pulse(input logic [3:0] k);
        @(posedge core_clk);
        cmd <= k;
        cyc(2);
        cmd <= 4'h0;
        cyc(4);
    endtask

    // Halt and reserved codes carry pc 0; bus unit fields unchecked where undefined
    function automatic bsp_boot_t exp_boot(input logic [5:0] s, output logic c);
        bsp_boot_t b;
        logic en;
        en = (s[2:1] == 2'b10) && s[5:4] != 2'b10;
        c = (s[5:4] == 2'b01) || (s[5:4] == 2'b11 && s[2:0] > CFG_ROM_MAX);
        b = '{BSP_SRC_HALT, 32'h0, en, en & s[3]};
        if (s[5:4] == 2'b00)
            b = '{BSP_SRC_EMU, PC_EMU, en, en & s[3]};
        if (s[5:4] == 2'b10)
            b.src = BSP_SRC_TRIST;
        if (s[5:4] == 2'b11)
        begin
            b.src = (s[2:0] <= CFG_ROM_MAX) ? BSP_SRC_ROM : (s[2:0] == CFG_EBU) ?
                BSP_SRC_EBU : (s[2:0] == CFG_BUS) ? BSP_SRC_BUS : BSP_SRC_RSVD;
            b.pc = (s[2:0] <= CFG_ROM_MAX) ? PC_ROM : en ? PC_EXT : 32'h0;
        end
        return b;
    endfunction

    initial
    begin
        cyc(20000);
        miscompares++;
        give_verdict;
    end

    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cmd} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        strap_sel = 6'h30;
        rst = 1'b1;
        cyc(2);
        rst <= 1'b0;
        check(32'({cpu_clk_en_q, sys_clk_en_q, pll_en_q, pm_mode_q, periph_clk_en_q}),
            32'h1cff);
        cyc(20);
        check(32'({sys_rst_q, hard_reset_output_q}), 32'h3);
        rd(OFS_SLPEN, 32'hff, 32'h00, 2'b00);
        rd(OFS_WAKEN, 32'hff, 32'hff, 2'b00);
        rd(OFS_PEREN, 32'hff, 32'hff, 2'b00);
        rd(8'h20, 32'h0, 32'h0, 2'b10);
        wr(8'h24, 32'h1, 2'b10);
        cyc(10);
        check(32'({sys_rst_q, hard_reset_output_q}), 32'h0);
        wr(OFS_PEREN, 32'h0f, 2'b00);
        cyc(3);
        check(32'(periph_clk_en_q), 32'h0f);
        wr(OFS_PEREN, 32'hff, 2'b00);
        wr(OFS_SLPEN, 32'h05, 2'b00);
        for (int m = 1; m <= 2; m++)
            for (int k = 1; k <= 3; k++)
            begin
                wr(OFS_CTRL, 32'(m), 2'b00);
                cyc(10);
                check(32'({pm_mode_q, cpu_clk_en_q, sys_clk_en_q, periph_clk_en_q}),
                    32'({2'(m), 2'b01, (m == 1) ? 8'hff : 8'h05}));
                pulse((m == 2) ? 4'h5 : 4'h0);
                check(32'(pm_mode_q), 32'(m));
                pulse(4'(k));
                check(32'({pm_mode_q, cpu_clk_en_q, periph_clk_en_q}), 32'h1ff);
            end
        wr(OFS_CTRL, 32'h1, 2'b00);
        cyc(3);
        pulse(4'h6);
        check(32'({sys_rst_q, hard_reset_output_q, pm_mode_q, cpu_clk_en_q}), 32'h19);
        cyc(30);
        foreach (tbl[i])
        begin
            strap_sel <= tbl[i];
            wr(OFS_CTRL, 32'h10, 2'b00);
            check(32'(hard_reset_output_q), 32'h1);
            cyc(32);
            eb = exp_boot(tbl[i], ec);
            check(boot_q.pc, eb.pc);
            check(32'(boot_q.src), 32'(eb.src));
            check(32'({boot_q.ebu_en, boot_q.ebu_master} & {2{ec}}),
                32'({eb.ebu_en, eb.ebu_master} & {2{ec}}));
            rd(OFS_BOOT, 32'hffffffff, eb.pc, 2'b00);
            rd(OFS_STAT, 32'h70, 32'(eb.src) << STAT_SRC_LSB, 2'b00);
            strap_sel <= 6'h00;
            cyc(3);
            check(32'(boot_q.src), 32'(eb.src));
        end
        check(32'({pm_mode_q, sys_clk_en_q, pll_en_q}), 32'hc);
        pulse(4'h1);
        check(32'(pm_mode_q), 32'h3);
        pulse(4'h4);
        cyc(60);
        check(32'({pm_mode_q, sys_clk_en_q, pll_en_q}), 32'h3);
        wr(OFS_CTRL, 32'h3, 2'b00);
        cyc(10);
        check(32'({pm_mode_q, sys_clk_en_q, pll_en_q, periph_clk_en_q}), 32'hc00);
        pulse(4'h4);
        cyc(60);
        check(32'({pm_mode_q, cpu_clk_en_q, sys_clk_en_q, pll_en_q}), 32'h7);
        give_verdict;
    end
endmodule

// file: verification/bsp_board_model.sv
// Partner model of board straps and wake sources
`timescale 1ns/100ps
module bsp_board_model
    import bsp_pkg::*;
(
    input wire logic core_clk,
    input wire logic [5:0] strap_sel,
    input wire logic [3:0] cmd,
    output logic debug_enable_strap,
    output logic break_in_strap,
    output logic [3:0] boot_cfg,
    output logic [NPER-1:0] periph_irq,
    output logic wdt_event,
    output logic wdt_reset_req,
    output logic nmi_n,
    output logic ext_wake
);
    assign {debug_enable_strap, break_in_strap, boot_cfg} = strap_sel;

    // Wake sources; NMI idles high so a request is a real fall
    always @(posedge core_clk)
    begin
        wdt_event <= (cmd == 4'h1);
        nmi_n <= (cmd != 4'h2);
        periph_irq <= (cmd == 4'h3) ? 8'h01 : (cmd == 4'h5) ? 8'h02 : 8'h00;
        ext_wake <= (cmd == 4'h4);
        wdt_reset_req <= (cmd == 4'h6);
    end
endmodule
